// ---- shared/fwd_pkg.sv ----
// Shared constants and types for the forward converter sequencer
package fwd_pkg;
    // Register port
    localparam int ADDR_WIDTH = 4;
    localparam int DATA_WIDTH = 32;
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_MASK = 4'h1;
    localparam logic [3:0] ADDR_CONTROL = 4'h2;
    localparam logic [3:0] ADDR_STATE = 4'h3;
    localparam logic [3:0] ADDR_FAULTS = 4'h4;
    localparam logic [3:0] ADDR_DELAYS = 4'h5;
    // Status bit positions
    localparam int EVT_WIDTH = 4;
    localparam int EVT_HARDSTOP = 0;
    localparam int EVT_RESTART = 1;
    localparam int EVT_SKIP = 2;
    localparam int EVT_CLAMP_TIMEOUT = 3;
    // Fault vector positions
    localparam int FAULT_WIDTH = 6;
    // Reset values
    localparam logic [3:0] MASK_RESET = 4'h0;
    localparam logic [7:0] DELAY_RESET = 8'h04;
    localparam int DELAY_WIDTH = 8;
    // Clamp timeout: 15 us at 20 MHz, rounded down
    localparam int CLK_HZ = 20000000;
    localparam int CLAMP_TIMEOUT_NS = 15000;
    localparam int CLAMP_TIMEOUT_CYCLES = (CLAMP_TIMEOUT_NS / 1000) * (CLK_HZ / 1000000);
    localparam int CLAMP_CNT_WIDTH = 10;

    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_DISCHARGE = 4'h1,
        ST_CHARGE = 4'h2,
        ST_RUN = 4'h4,
        ST_IDLE = 4'h8
    } seq_state_type;

    // Pulse phase states, one-hot
    typedef enum logic [3:0] {
        PH_WAIT = 4'h1,
        PH_PRIMARY = 4'h2,
        PH_BACKEND = 4'h4,
        PH_CLAMP = 4'h8
    } phase_state_type;
endpackage : fwd_pkg

// ---- shared/drive_if.sv ----
// Gate-drive command bundle between sequencer and pulse engine
interface drive_if;
    import fwd_pkg::*;
    logic switchEnable;
    logic cycleStart;
    logic compAbove;
    logic primaryDrive;
    logic clamp_gate_drive;
    logic sync_rect_drive;
    logic skipped;
    logic clampTimedOut;
    logic [DELAY_WIDTH-1:0] backendDelay;
    modport seq (output switchEnable, output cycleStart, output compAbove,
        output backendDelay, input primaryDrive, input clamp_gate_drive,
        input sync_rect_drive, input skipped, input clampTimedOut);
    modport eng (input switchEnable, input cycleStart, input compAbove,
        input backendDelay, output primaryDrive, output clamp_gate_drive,
        output sync_rect_drive, output skipped, output clampTimedOut);
endinterface : drive_if

// ---- design/clamp_timeout.sv ----
// Continuous-on timer for the clamp gate drive
module clamp_timeout
    import fwd_pkg::*;
#(
    parameter int LIMIT = CLAMP_TIMEOUT_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Drive observed
    input wire logic clampOn,
    // Timeout flag
    output logic expired
);
    logic [CLAMP_CNT_WIDTH-1:0] count;

    // ==================================================
    // Counter
    // clear when off
    always_ff @(posedge clk)
    begin
        if (srst || !clampOn)
            count <= '0;
        else if (!expired)
            count <= count + 1'b1;
    end

    assign expired = (count >= CLAMP_CNT_WIDTH'(LIMIT - 1));
endmodule // clamp_timeout

// ---- design/pulse_engine.sv ----
// Per-cycle primary, clamp and sync-rectifier pulse sequencing
module pulse_engine
    import fwd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Command bundle
    drive_if.eng drv
);
    phase_state_type phase;
    phase_state_type next_phase;
    logic [DELAY_WIDTH-1:0] delayCount;
    logic timerDone;
    logic clampExpired;

    clamp_timeout #(.LIMIT(CLAMP_TIMEOUT_CYCLES)) u_timeout (
        .clk(clk),
        .srst(srst),
        .clampOn(drv.clamp_gate_drive),
        .expired(clampExpired)
    );

    assign timerDone = (delayCount == '0);

    // ==================================================
    // Phase selection
    always_comb
    begin
        next_phase = phase;
        case (phase)
            PH_WAIT:
                if (drv.switchEnable && drv.cycleStart && drv.compAbove)
                    next_phase = PH_PRIMARY;
            PH_PRIMARY:
                if (!drv.switchEnable || !drv.compAbove || drv.cycleStart)
                    next_phase = PH_BACKEND;
            PH_BACKEND:
                if (!drv.switchEnable)
                    next_phase = PH_WAIT;
                else if (timerDone)
                    next_phase = PH_CLAMP;
            PH_CLAMP:
                // next pulse starts from clamp phase
                if (!drv.switchEnable)
                    next_phase = PH_WAIT;
                else if (drv.cycleStart && drv.compAbove)
                    next_phase = PH_PRIMARY;
                else if (drv.cycleStart || clampExpired)
                    next_phase = PH_WAIT;
            default:
                next_phase = PH_WAIT;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            phase <= PH_WAIT;
        else
            phase <= next_phase;
    end

    // Back-end delay reloads on entry so timing counts from primary fall
    always_ff @(posedge clk)
    begin
        if (srst || phase != PH_BACKEND)
            delayCount <= drv.backendDelay;
        else if (!timerDone)
            delayCount <= delayCount - 1'b1;
    end

    // ==================================================
    // Drive outputs
    // sequencing restored per cycle
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            drv.primaryDrive <= 1'b0;
            drv.clamp_gate_drive <= 1'b0;
            drv.sync_rect_drive <= 1'b0;
        end
        else
        begin
            drv.primaryDrive <= (next_phase == PH_PRIMARY);
            drv.clamp_gate_drive <= (next_phase == PH_CLAMP);
            drv.sync_rect_drive <= (next_phase == PH_BACKEND) || (next_phase == PH_CLAMP);
        end
    end

    // a cycle start in clamp phase is a new cycle too
    assign drv.skipped = ((phase == PH_WAIT) || (phase == PH_CLAMP)) && drv.switchEnable
        && drv.cycleStart && !drv.compAbove;
    assign drv.clampTimedOut = (phase == PH_CLAMP) && clampExpired;

    AST_CLAMP_TIMEOUT: assert property (@(posedge clk) disable iff (srst)
        drv.clamp_gate_drive && clampExpired |=> !drv.clamp_gate_drive)
        else $error("clamp drive stayed on past timeout");
    AST_COMP_DROP: assert property (@(posedge clk) disable iff (srst)
        drv.primaryDrive && !drv.compAbove |=> !drv.primaryDrive)
        else $error("primary drive held after comp dropped");
    AST_SKIP: assert property (@(posedge clk) disable iff (srst)
        drv.skipped |=> !drv.primaryDrive && !drv.clamp_gate_drive)
        else $error("pulse emitted on skipped cycle");
endmodule // pulse_engine

// ---- design/forward_pwm_fault_sequencer.sv ----
// Fault hard-stop, hiccup restart and drive sequencing for a forward controller
// Operation
// - Any fault stops switching at once and rapidly discharges both ramps.
// - Faults: shutdown request, overvoltage, overcurrent, supply rail, thermal, supply undervoltage.
// - Below low threshold, recharge slow ramp only if all faults cleared.
// - Persistent overcurrent repeats discharge and recharge forever: hiccup.
// - Hiccup dead time is the slow ramp recharge to enable level.
// - Comp falling while primary high turns primary off immediately.
// - Comp still low at cycle start skips primary, clamp, rectifier pulses.
// - Next needed pulse restores correct clamp and rectifier sequencing.
// - Clamp drive forced low after fixed on-time timeout.
// - Switching only above enable level; comp ramp charges only after.
// - Below enable level, stop switching and discharge comp ramp.
module forward_pwm_fault_sequencer
    import fwd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register port
    input wire logic [fwd_pkg::ADDR_WIDTH-1:0] regAddr,
    input wire logic [fwd_pkg::DATA_WIDTH-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [fwd_pkg::DATA_WIDTH-1:0] regRdata,
    output logic irq,
    // Fault flags
    input wire logic shutdownRequest,
    input wire logic input_overvoltage_sense,
    input wire logic overcurrent_sense,
    input wire logic internal_supply_rail,
    input wire logic thermalShutdown,
    input wire logic supplyUndervoltage,
    // Ramp and loop comparators
    input wire logic slowRampAboveEnable,
    input wire logic slowRampBelowLow,
    input wire logic compAboveThreshold,
    input wire logic cycleStart,
    // Ramp commands
    output logic slow_softstart_ramp_charge,
    output logic slow_softstart_ramp_discharge,
    output logic comp_softstart_ramp_charge,
    output logic comp_softstart_ramp_discharge,
    // Gate drives
    output logic primaryDrive,
    output logic clamp_gate_drive,
    output logic sync_rect_drive
);
    import fwd_pkg::*;

    seq_state_type state;
    seq_state_type next_state;
    logic [FAULT_WIDTH-1:0] faults;
    logic anyFault;
    logic [EVT_WIDTH-1:0] status;
    logic [EVT_WIDTH-1:0] mask;
    logic [EVT_WIDTH-1:0] events;
    logic [DELAY_WIDTH-1:0] backendDelay;
    logic forceOff;
    logic switchAllowed;
    logic selStatus;
    logic selMask;
    logic selControl;
    logic selState;
    logic selFaults;
    logic selDelays;
    logic [DATA_WIDTH-1:0] readValue;

    drive_if drv ();

    // ==================================================
    // Fault gathering
    // flags used directly, already synchronous
    assign faults = {supplyUndervoltage, thermalShutdown, internal_supply_rail,
        overcurrent_sense, input_overvoltage_sense, shutdownRequest};
    assign anyFault = |faults;

    // ==================================================
    // Ramp sequencer
    always_comb
    begin
        next_state = state;
        case (state)
            ST_DISCHARGE:
                if (slowRampBelowLow && !anyFault && !forceOff)
                    next_state = ST_CHARGE;
            ST_CHARGE:
                if (anyFault)
                    next_state = ST_DISCHARGE;
                else if (slowRampAboveEnable)
                    next_state = ST_RUN;
            ST_RUN:
                if (anyFault)
                    next_state = ST_DISCHARGE;
                else if (!slowRampAboveEnable)
                    next_state = ST_CHARGE;
            ST_IDLE:
                next_state = ST_DISCHARGE;
            default:
                next_state = ST_DISCHARGE;
        endcase
    end

    // Start in discharge so a cold start takes the same fault-checked path
    always_ff @(posedge clk)
    begin
        if (srst)
            state <= ST_DISCHARGE;
        else
            state <= next_state;
    end

    assign switchAllowed = (state == ST_RUN) && slowRampAboveEnable && !anyFault && !forceOff;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            slow_softstart_ramp_charge <= 1'b0;
            slow_softstart_ramp_discharge <= 1'b1;
            comp_softstart_ramp_charge <= 1'b0;
            comp_softstart_ramp_discharge <= 1'b1;
        end
        else
        begin
            slow_softstart_ramp_discharge <= (next_state == ST_DISCHARGE);
            slow_softstart_ramp_charge <= (next_state != ST_DISCHARGE);
            comp_softstart_ramp_charge <= (next_state == ST_RUN) && slowRampAboveEnable;
            comp_softstart_ramp_discharge <= !((next_state == ST_RUN) && slowRampAboveEnable);
        end
    end

    // ==================================================
    // Pulse engine
    assign drv.switchEnable = switchAllowed;
    assign drv.cycleStart = cycleStart;
    assign drv.compAbove = compAboveThreshold;
    assign drv.backendDelay = backendDelay;

    pulse_engine u_engine (
        .clk(clk),
        .srst(srst),
        .drv(drv.eng)
    );

    assign primaryDrive = drv.primaryDrive;
    assign clamp_gate_drive = drv.clamp_gate_drive;
    assign sync_rect_drive = drv.sync_rect_drive;

    // ==================================================
    // Events and interrupt
    assign events[EVT_HARDSTOP] = anyFault && (state != ST_DISCHARGE);
    assign events[EVT_RESTART] = (state == ST_DISCHARGE) && (next_state == ST_CHARGE);
    assign events[EVT_SKIP] = drv.skipped;
    assign events[EVT_CLAMP_TIMEOUT] = drv.clampTimedOut;

    // Set wins over the read-clear
    always_ff @(posedge clk)
    begin
        if (srst)
            status <= '0;
        else if (selStatus && regRead)
            status <= events;
        else
            status <= status | events;
    end

    assign irq = |(status & mask);

    // ==================================================
    // Register port
    assign selStatus = (regAddr == ADDR_STATUS);
    assign selMask = (regAddr == ADDR_MASK);
    assign selControl = (regAddr == ADDR_CONTROL);
    assign selState = (regAddr == ADDR_STATE);
    assign selFaults = (regAddr == ADDR_FAULTS);
    assign selDelays = (regAddr == ADDR_DELAYS);

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            mask <= MASK_RESET;
            forceOff <= 1'b0;
            backendDelay <= DELAY_RESET;
        end
        else if (regWrite)
        begin
            if (selMask)
                mask <= regWdata[EVT_WIDTH-1:0];
            if (selControl)
                forceOff <= regWdata[0];
            if (selDelays)
                backendDelay <= regWdata[DELAY_WIDTH-1:0];
        end
    end

    // Unmapped addresses read as zero
    assign readValue = selStatus ? DATA_WIDTH'(status)
        : selMask ? DATA_WIDTH'(mask)
        : selControl ? DATA_WIDTH'(forceOff)
        : selState ? DATA_WIDTH'(state)
        : selFaults ? DATA_WIDTH'(faults)
        : selDelays ? DATA_WIDTH'(backendDelay)
        : '0;

    always_ff @(posedge clk)
    begin
        if (srst)
            regRdata <= '0;
        else if (regRead)
            regRdata <= readValue;
        else
            regRdata <= '0;
    end

    // ==================================================
    // Checks
    // fault stops switching
    AST_FAULT_STOP: assert property (@(posedge clk) disable iff (srst)
        anyFault |=> (!slow_softstart_ramp_charge && !comp_softstart_ramp_charge)
            ##1 !primaryDrive)
        else $error("switching continued under fault");
    AST_NO_RESTART: assert property (@(posedge clk) disable iff (srst)
        (state == ST_DISCHARGE) && anyFault |=> (state == ST_DISCHARGE))
        else $error("ramp restarted with fault present");
    AST_RESTART: assert property (@(posedge clk) disable iff (srst)
        (state == ST_DISCHARGE) && slowRampBelowLow && !anyFault && !forceOff
            |=> (state == ST_CHARGE) ##0 slow_softstart_ramp_charge)
        else $error("ramp did not restart when clear");
    AST_HICCUP: assert property (@(posedge clk) disable iff (srst)
        (state == ST_RUN) && overcurrent_sense |=> (state == ST_DISCHARGE))
        else $error("overcurrent did not trigger hiccup");
    AST_COMP_HELD: assert property (@(posedge clk) disable iff (srst)
        !slowRampAboveEnable |=> comp_softstart_ramp_discharge && !comp_softstart_ramp_charge)
        else $error("comp ramp charged below enable");
    AST_RUN_ONLY: assert property (@(posedge clk) disable iff (srst)
        $rose(primaryDrive) |-> $past(state) == ST_RUN)
        else $error("primary drive rose outside run");
endmodule // forward_pwm_fault_sequencer

// ---- tb/ramp_model.sv ----
// Behavioural slow soft-start ramp with its threshold comparators
module ramp_model #(
    parameter int LOW = 2,
    parameter int EN = 20,
    parameter int TOP = 30
)
(
    // Clock
    input wire logic clk,
    // Ramp commands
    input wire logic charge,
    input wire logic discharge,
    input wire logic sag,
    // Comparator flags
    output logic aboveEnable = 1'b0,
    output logic belowLow = 1'b1
);
    timeunit 1ns;
    timeprecision 1ns;
    int level = 0;
    // ====
    // Ramp level
    // recharge sets dead time
    // Sag wins over charge, standing in for a soft-stop pull
    always @(posedge clk)
    begin
        if (discharge || sag)
            level <= (level > 3) ? level - 3 : 0;
        else if (charge && level < TOP)
            level <= level + 1;
    end
    // ====
    // Comparators
    // flags change once per clock
    always @(posedge clk)
    begin
        aboveEnable <= level >= EN;
        belowLow <= level < LOW;
    end
endmodule // ramp_model

// ---- tb/testbench.sv ----
// Self-checking bench for the forward converter fault sequencer
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin failures++; \
    $display("BAD %s exp %h got %h", nm, ex, got); end end
module testbench;
    import fwd_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    // ====
    // Signals
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [31:0] regRdata;
    logic irq;
    logic [5:0] faults = 6'h01;
    logic ocShort = 1'b0;
    logic ocHit = 1'b0;
    logic compAbove = 1'b0;
    logic cycleStart = 1'b0;
    logic sag = 1'b0;
    logic aboveEn, belowLow, sCh, sDis, cCh, cDis, prim, clampD, syncD;
    logic prevDis = 1'b0;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;
    int stops = 0;
    wire ocSense = faults[2] | ocHit;
    wire [5:0] drv = {cDis, sCh, cCh, clampD, syncD, prim};
    forward_pwm_fault_sequencer dut (
        .clk(clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .irq(irq),
        .shutdownRequest(faults[0]), .input_overvoltage_sense(faults[1]),
        .overcurrent_sense(ocSense), .internal_supply_rail(faults[3]),
        .thermalShutdown(faults[4]), .supplyUndervoltage(faults[5]),
        .slowRampAboveEnable(aboveEn), .slowRampBelowLow(belowLow),
        .compAboveThreshold(compAbove), .cycleStart(cycleStart),
        .slow_softstart_ramp_charge(sCh), .slow_softstart_ramp_discharge(sDis),
        .comp_softstart_ramp_charge(cCh), .comp_softstart_ramp_discharge(cDis),
        .primaryDrive(prim), .clamp_gate_drive(clampD), .sync_rect_drive(syncD));
    ramp_model ramp (.clk(clk), .charge(sCh), .discharge(sDis), .sag(sag),
        .aboveEnable(aboveEn), .belowLow(belowLow));
    // ====
    // Clock, timeout, shorted-output sense
    initial
    begin
        forever #25 clk = ~clk;
    end
    // Sense trips only while the switch conducts, as a real short does
    always @(posedge clk)
    begin
        ocHit <= ocShort && prim;
        prevDis <= sDis;
        if (sDis && !prevDis)
            stops <= stops + 1;
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures++;
            finish_test();
        end
    end
    // ====
    // Shared tasks
    task automatic finish_test();
        if (failures == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 v = regRdata;
    endtask
    task automatic kick();
        @(posedge clk);
        cycleStart <= 1'b1;
        @(posedge clk);
        cycleStart <= 1'b0;
        #1;
    endtask
    // Bounded wait on one drive bit
    task automatic wt(input int b, input logic v, input int mx, output int n);
        n = 0;
        while (drv[b] !== v && n < mx)
        begin
            @(posedge clk);
            #1 n++;
        end
        `CHK("wait", 1'b1, n < mx)
    endtask
    // ====
    // Scenarios
    task automatic t_start();
        int n;
        logic [31:0] v;
        #1 `CHK("rstDrv", 3'h0, {clampD, syncD, prim})
        `CHK("rstRamp", 3'h6, {sDis, cDis, sCh})
        rd(4'h1, v);
        `CHK("mask", 32'h0, v)
        rd(4'h5, v);
        `CHK("delays", 32'h4, v)
        rd(4'h3, v);
        `CHK("heldOff", 32'h1, v)
        rd(4'h4, v);
        `CHK("faultRst", 32'h1, v)
        @(posedge clk);
        faults <= 6'h00;
        wt(4, 1'b1, 20, n);
        `CHK("compWait", 1'b0, cCh)
        wt(3, 1'b1, 80, n);
        `CHK("enLevel", 1'b1, aboveEn)
        rd(4'h3, v);
        `CHK("run", 32'h4, v)
    endtask
    task automatic t_pulse(input logic [7:0] d, output int n);
        int k;
        wr(4'h5, {24'h0, d});
        @(posedge clk);
        compAbove <= 1'b1;
        kick();
        wt(0, 1'b1, 4, k);
        @(posedge clk);
        compAbove <= 1'b0;
        wt(0, 1'b0, 3, k);
        `CHK("syncOn", 1'b1, syncD)
        wt(2, 1'b1, 40, n);
        `CHK("syncClamp", 1'b1, syncD)
    endtask
    task automatic t_pulses();
        int n1, n2, k;
        logic [31:0] v;
        logic seen;
        t_pulse(8'h04, n1);
        // Long first clamp so a stale timer would trip early later
        repeat (20) @(posedge clk);
        kick();
        repeat (3) @(posedge clk);
        seen = 1'b0;
        repeat (8)
        begin
            @(posedge clk);
            #1 seen = seen | prim | clampD;
        end
        `CHK("skipped", 1'b0, seen)
        rd(4'h0, v);
        `CHK("skipEvt", 1'b1, v[2])
        t_pulse(8'h09, n2);
        `CHK("delayStep", 5, n2 - n1)
        wt(2, 1'b0, 400, k);
        `CHK("clampTo", 1'b1, k >= CLAMP_TIMEOUT_CYCLES - 2 && k <= CLAMP_TIMEOUT_CYCLES + 1)
        `CHK("irqMasked", 1'b0, irq)
        wr(4'h1, 32'h8);
        #1 `CHK("irqOn", 1'b1, irq)
        rd(4'h0, v);
        `CHK("toEvt", 1'b1, v[3])
        `CHK("irqOff", 1'b0, irq)
        wr(4'hF, 32'hF);
        rd(4'hF, v);
        `CHK("unmapped", 32'h0, v)
        rd(4'h1, v);
        `CHK("maskKept", 32'h8, v)
    endtask
    task automatic t_faults();
        int k;
        logic [31:0] v;
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clk);
            compAbove <= 1'b1;
            kick();
            wt(0, 1'b1, 4, k);
            @(posedge clk);
            faults <= 6'h01 << i;
            @(posedge clk);
            @(posedge clk);
            #1 `CHK("stopped", 3'h0, {clampD, syncD, prim})
            `CHK("ramps", 3'h6, {sDis, cDis, sCh})
            rd(4'h4, v);
            `CHK("faultVec", 32'h1 << i, v)
            repeat (20) @(posedge clk);
            rd(4'h3, v);
            `CHK("held", 32'h1, v)
            @(posedge clk);
            faults <= 6'h00;
            wt(3, 1'b1, 80, k);
        end
        rd(4'h0, v);
        `CHK("stopEvt", 1'b1, v[0])
    endtask
    task automatic t_sag();
        int k;
        logic [31:0] v;
        @(posedge clk);
        sag <= 1'b1;
        wt(5, 1'b1, 30, k);
        `CHK("noSwitch", 1'b0, prim)
        `CHK("compChg", 1'b0, cCh)
        rd(4'h3, v);
        `CHK("charge", 32'h2, v)
        @(posedge clk);
        sag <= 1'b0;
        wt(3, 1'b1, 80, k);
    endtask
    task automatic t_hiccup();
        int k, s0;
        s0 = stops;
        @(posedge clk);
        ocShort <= 1'b1;
        compAbove <= 1'b1;
        repeat (12)
        begin
            kick();
            repeat (30) @(posedge clk);
        end
        `CHK("hiccups", 1'b1, stops - s0 >= 2)
        @(posedge clk);
        ocShort <= 1'b0;
        wt(3, 1'b1, 80, k);
    endtask
    // ====
    // Main sequence
    initial
    begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        t_start();
        t_pulses();
        t_faults();
        t_sag();
        t_hiccup();
        finish_test();
    end
endmodule // testbench
